// ### pdm_defines.svh
// Timing and geometry constants for the page-mode DRAM module controller.
// Assumes a 25 MHz controller clock; counts are derived from times in ns.
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_CLK_PERIOD_NS 40
`define PDM_ADDR_HALF_W 9
`define PDM_DATA_W 36
`define PDM_LANES 4
`define PDM_ROWS 512
// Power-up pause in microseconds, rounded up to cycles.
`define PDM_POWERUP_US 100
`define PDM_POWERUP_CYC ((`PDM_POWERUP_US * 1000 + `PDM_CLK_PERIOD_NS - 1) / `PDM_CLK_PERIOD_NS)
`define PDM_WAKE_CYCLES 8
// Refresh interval in ms; one row every interval/rows, rounded down.
`define PDM_REFRESH_MS 8
`define PDM_ROW_REFRESH_CYC ((`PDM_REFRESH_MS * 1000000 / `PDM_ROWS) / `PDM_CLK_PERIOD_NS)
// Strobe phase lengths in cycles: row precharge, row-to-column delay, column pulse.
`define PDM_PRECHARGE_NS 70
`define PDM_PRECHARGE_CYC ((`PDM_PRECHARGE_NS + `PDM_CLK_PERIOD_NS - 1) / `PDM_CLK_PERIOD_NS)
`define PDM_ROW_TO_COL_NS 25
`define PDM_ROW_TO_COL_CYC ((`PDM_ROW_TO_COL_NS + `PDM_CLK_PERIOD_NS - 1) / `PDM_CLK_PERIOD_NS)
`define PDM_ACCESS_NS 100
`define PDM_ACCESS_CYC ((`PDM_ACCESS_NS + `PDM_CLK_PERIOD_NS - 1) / `PDM_CLK_PERIOD_NS)

`endif

// ### pdm_pkg.sv
// Types shared by the page-mode DRAM module controller.
// Assumes nothing of its surroundings.
package pdm_pkg;
  typedef enum logic [3:0] {
    PDM_POWERUP = 4'h0,
    PDM_IDLE = 4'h1,
    PDM_ROW = 4'h2,
    PDM_COL = 4'h3,
    PDM_COL_END = 4'h4,
    PDM_PAGE_WAIT = 4'h5,
    PDM_PRECHARGE = 4'h6,
    PDM_REF_CAS = 4'h7,
    PDM_REF_RAS = 4'h8
  } pdm_state_e;
endpackage : pdm_pkg

// ### pdm_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module pdm_sync #(
  parameter int WIDTH = 36
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Data.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  // First stage is read only by the second stage.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      syncOut <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule : pdm_sync
`default_nettype wire

// ### pdm_ctrl.sv
// Controller that drives a 36-bit fast-page-mode DRAM module through its pins.
// Assumes a 25 MHz clock, a synchronous reset and a module wired to these pins.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_ctrl import pdm_pkg::*; #(
  parameter int POWERUP_CYC = `PDM_POWERUP_CYC,
  parameter int REFRESH_CYC = `PDM_ROW_REFRESH_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // User request port.
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqSide,
  input wire logic [17:0] reqAddr,
  input wire logic [35:0] reqWdata,
  input wire logic [3:0] reqLanes,
  input wire logic reqPageNext,
  output logic reqReady,
  output logic rspValid,
  output logic [35:0] rspRdata,
  output logic initDone,
  // DRAM module pins.
  output logic row_strobe_side_one_n,
  output logic row_strobe_side_two_n,
  output logic column_strobe_lane0_n,
  output logic column_strobe_lane1_n,
  output logic column_strobe_lane2_n,
  output logic column_strobe_lane3_n,
  output logic writeEnable_n,
  output logic [8:0] muxed_address_bus,
  input wire logic [35:0] dataIn,
  output logic [35:0] dataOut,
  output logic dataOe_n
);
  pdm_state_e state_reg, state_next;
  logic [12:0] timer_reg, timer_next;
  logic [REFRESH_CYC > 1 ? $clog2(REFRESH_CYC+1)-1 : 0:0] refCnt_reg;
  logic refPending_reg;
  logic [3:0] wakeCnt_reg, wakeCnt_next;
  logic initDone_next;
  logic sideReg, writeReg;
  logic [3:0] lanesReg;
  // Column half is kept here, so the user may change its request once it is taken.
  logic [8:0] colAddr_reg;
  logic [35:0] dataSync;
  logic rasAll_n, casAll_n;
  logic [3:0] casLanes_n;

  // Column strobes of the selected lanes.
  function automatic logic [3:0] lane_strobes(input logic on, input logic [3:0] lanes);
    lane_strobes = on ? ~lanes : 4'hF;
  endfunction : lane_strobes

  // Read data comes from a pin, so it is synchronised before sampling.
  pdm_sync #(.WIDTH(36)) uSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(dataIn),
    .syncOut(dataSync)
  );

  wire timerDone = (timer_reg == 13'h0000);
  wire refDue = (refCnt_reg == '0);
  wire startAccess = (state_reg == PDM_IDLE) && reqValid && !refPending_reg && initDone;
  wire startRefresh = (state_reg == PDM_IDLE) && (refPending_reg || !initDone);

  // Sequencer.
  always_comb begin
    state_next = state_reg;
    timer_next = timerDone ? timer_reg : timer_reg - 13'h0001;
    wakeCnt_next = wakeCnt_reg;
    initDone_next = initDone;
    rasAll_n = 1'b1;
    casAll_n = 1'b1;
    case (state_reg)
      PDM_POWERUP: begin
        if (timerDone) begin
          state_next = PDM_IDLE;
        end
      end
      PDM_IDLE: begin
        if (startRefresh) begin
          state_next = PDM_REF_CAS;
          timer_next = 13'h0000;
        end else if (startAccess) begin
          state_next = PDM_ROW;
          timer_next = 13'(`PDM_ROW_TO_COL_CYC);
        end
      end
      PDM_ROW: begin
        rasAll_n = 1'b0;
        if (timerDone) begin
          state_next = PDM_COL;
          timer_next = 13'(`PDM_ACCESS_CYC + 2);
        end
      end
      PDM_COL: begin
        rasAll_n = 1'b0;
        casAll_n = 1'b0;
        if (timerDone) begin
          state_next = PDM_COL_END;
        end
      end
      PDM_COL_END: begin
        rasAll_n = 1'b0;
        state_next = PDM_PAGE_WAIT;
      end
      PDM_PAGE_WAIT: begin
        rasAll_n = 1'b0;
        if (reqValid && reqPageNext && reqWrite == writeReg && !refPending_reg) begin
          state_next = PDM_COL;
          timer_next = 13'(`PDM_ACCESS_CYC + 2);
        end else begin
          state_next = PDM_PRECHARGE;
          timer_next = 13'(`PDM_PRECHARGE_CYC);
        end
      end
      PDM_REF_CAS: begin
        casAll_n = 1'b0;
        state_next = PDM_REF_RAS;
        timer_next = 13'(`PDM_ACCESS_CYC);
      end
      PDM_REF_RAS: begin
        casAll_n = 1'b0;
        rasAll_n = 1'b0;
        if (timerDone) begin
          state_next = PDM_PRECHARGE;
          timer_next = 13'(`PDM_PRECHARGE_CYC);
          if (!initDone) begin
            wakeCnt_next = wakeCnt_reg + 4'h1;
            initDone_next = (wakeCnt_reg == 4'(`PDM_WAKE_CYCLES - 1));
          end
        end
      end
      PDM_PRECHARGE: begin
        if (timerDone) begin
          state_next = PDM_IDLE;
        end
      end
      default: begin
        state_next = PDM_IDLE;
      end
    endcase
  end

  // Sequencer registers and the refresh interval timer.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= PDM_POWERUP;
      timer_reg <= 13'(POWERUP_CYC);
      wakeCnt_reg <= 4'h0;
      initDone <= 1'b0;
      refCnt_reg <= '0;
      refPending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      wakeCnt_reg <= wakeCnt_next;
      initDone <= initDone_next;
      refCnt_reg <= refDue ? $bits(refCnt_reg)'(REFRESH_CYC - 1) : refCnt_reg - 1'b1;
      // A new due tick wins over the clear at refresh end, so no row is skipped.
      refPending_reg <= refDue | (refPending_reg & !(state_reg == PDM_REF_RAS && timerDone));
    end
  end

  // Access latch: side, direction and lanes are fixed for the whole row cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sideReg <= 1'b0;
      writeReg <= 1'b0;
      lanesReg <= 4'h0;
      colAddr_reg <= 9'h000;
    end else if (startAccess) begin
      sideReg <= reqSide;
      writeReg <= reqWrite;
      lanesReg <= reqLanes;
      colAddr_reg <= reqAddr[8:0];
    end
  end

  assign casLanes_n = lane_strobes(!casAll_n, (state_reg == PDM_REF_CAS ||
                                   state_reg == PDM_REF_RAS) ? 4'hF : lanesReg);
  wire pageTake = (state_reg == PDM_PAGE_WAIT) && (state_next == PDM_COL);
  wire readSample = (state_reg == PDM_COL) && timerDone && !writeReg;

  // Pin drivers, all registered; row and column halves are set up a cycle ahead.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      row_strobe_side_one_n <= 1'b1;
      row_strobe_side_two_n <= 1'b1;
      {column_strobe_lane3_n, column_strobe_lane2_n,
       column_strobe_lane1_n, column_strobe_lane0_n} <= 4'hF;
      writeEnable_n <= 1'b1;
      muxed_address_bus <= 9'h000;
      dataOut <= 36'h0;
      dataOe_n <= 1'b1;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= 36'h0;
    end else begin
      // Refresh strobes both sides at once.
      row_strobe_side_one_n <= rasAll_n | (sideReg & !(state_next == PDM_REF_RAS ||
                               state_reg == PDM_REF_RAS));
      row_strobe_side_two_n <= rasAll_n | (!sideReg & !(state_next == PDM_REF_RAS ||
                               state_reg == PDM_REF_RAS));
      {column_strobe_lane3_n, column_strobe_lane2_n,
       column_strobe_lane1_n, column_strobe_lane0_n} <= casLanes_n;
      if (startAccess) begin
        muxed_address_bus <= reqAddr[17:9];
        writeEnable_n <= !reqWrite;
        dataOut <= reqWdata;
        dataOe_n <= !reqWrite;
      end else if (state_reg == PDM_ROW && timerDone) begin
        muxed_address_bus <= colAddr_reg;
      end else if (pageTake) begin
        muxed_address_bus <= reqAddr[8:0];
        dataOut <= reqWdata;
      end else if (state_next == PDM_PRECHARGE || state_next == PDM_IDLE) begin
        writeEnable_n <= 1'b1;
        dataOe_n <= 1'b1;
      end
      reqReady <= (state_next == PDM_ROW && state_reg == PDM_IDLE) || pageTake;
      rspValid <= readSample || (state_reg == PDM_COL && timerDone && writeReg);
      if (readSample) begin
        rspRdata <= dataSync;
      end
    end
  end
endmodule : pdm_ctrl
`default_nettype wire

// ### pdm_ctrl_assertions.sv
// Checker on the pin side of the page-mode DRAM controller.
// Assumes it is bound into pdm_ctrl, clocked by mclk with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl_assertions #(
  parameter int POWERUP_CYC = 10,
  parameter int REFRESH_CYC = 40
) (
  // Clock, reset and status.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic initDone,
  // DRAM pins.
  input wire logic row_strobe_side_one_n,
  input wire logic row_strobe_side_two_n,
  input wire logic column_strobe_lane0_n,
  input wire logic column_strobe_lane1_n,
  input wire logic column_strobe_lane2_n,
  input wire logic column_strobe_lane3_n,
  input wire logic writeEnable_n,
  input wire logic [8:0] muxed_address_bus,
  input wire logic dataOe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  localparam int GAP_MAX = 2 * REFRESH_CYC + 32;
  // Any row strobe low opens a row cycle; any lane low opens a column phase.
  wire rowLow = !(row_strobe_side_one_n && row_strobe_side_two_n);
  wire colLow = !(column_strobe_lane0_n && column_strobe_lane1_n && column_strobe_lane2_n
    && column_strobe_lane3_n);
  logic [15:0] upCnt;
  logic [15:0] refGap;
  logic [3:0] wakeCnt;
  // Counters saturate, so a long run can never wrap them back under a bound.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upCnt <= 16'h0000;
      refGap <= 16'h0000;
      wakeCnt <= 4'h0;
    end else begin
      upCnt <= upCnt + {15'h0000, upCnt != 16'hFFFF};
      refGap <= (rowLow && colLow && !$past(rowLow)) ? 16'h0000 :
        refGap + {15'h0000, refGap != 16'hFFFF};
      wakeCnt <= wakeCnt + {3'h0, rowLow && !$past(rowLow) && wakeCnt != 4'hF};
    end
  end
  sequence s_precharge;
    !rowLow [*2];
  endsequence
  a_powerup_wait: assert property ($rose(rowLow) |-> upCnt >= POWERUP_CYC - 1)
    else $error("row strobe fell before the power-up pause");
  a_wake_count: assert property ($rose(initDone) |-> wakeCnt >= 4'h8)
    else $error("ready before eight wake-up row cycles");
  a_refresh_order: assert property ($rose(rowLow) && colLow |-> $past(colLow))
    else $error("column and row strobes fell together");
  a_early_write: assert property ($rose(colLow) && !writeEnable_n |-> $past(!writeEnable_n) && !dataOe_n)
    else $error("write enable did not lead the column strobe");
  a_column_steady: assert property (colLow && $past(colLow) |-> $stable(writeEnable_n) && $stable(muxed_address_bus))
    else $error("write enable or address moved in a column phase");
  a_precharge_time: assert property ($fell(rowLow) |-> s_precharge)
    else $error("row strobe precharge too short");
  a_one_side: assert property ($rose(rowLow) && !colLow |-> row_strobe_side_one_n != row_strobe_side_two_n)
    else $error("access opened both sides");
  a_refresh_gap: assert property (initDone |-> refGap < GAP_MAX)
    else $error("refresh interval overrun");
  a_answer_bound: assert property (reqReady |-> ##[1:40] rspValid)
    else $error("no response after a taken request");
endmodule : pdm_ctrl_assertions
`default_nettype wire

// ### pdm_dram_model.sv
// Behavioural model of the 36-bit page-mode DRAM module.
// Assumes strobes move on controller clock edges; lane i owns data bits 9i+8..9i.
`timescale 1ns/1ps
`default_nettype none
module pdm_dram_model #(
  parameter int ACC_NS = 20
) (
  // Strobes, write enable and address.
  input wire logic row_strobe_side_one_n,
  input wire logic row_strobe_side_two_n,
  input wire logic [3:0] colStrobe_n,
  input wire logic writeEnable_n,
  input wire logic [8:0] muxed_address_bus,
  // Data bus halves.
  input wire logic [35:0] dataOut,
  input wire logic dataOe_n,
  output logic [35:0] dataIn
);
  logic [35:0] mem [bit [18:0]];
  logic [35:0] lastQ = 36'h000000000;
  logic [8:0] rowAddr = 9'h000;
  logic side = 1'b0;
  logic rowOpen = 1'b0;
  logic [18:0] key;
  wire rowLow = !(row_strobe_side_one_n && row_strobe_side_two_n);
  wire colLow = (colStrobe_n != 4'hF);
  // Column already low at the row fall means a counter refresh, so the address is ignored.
  always @(posedge rowLow) begin
    rowOpen = !colLow;
    rowAddr = muxed_address_bus;
    side = row_strobe_side_one_n;
  end
  // Raising the row strobe closes the page and precharges.
  always @(negedge rowLow) rowOpen = 1'b0;
  // Column fall takes the column half; early-write data lands on this later edge.
  always @(posedge colLow) begin
    key = {side, rowAddr, muxed_address_bus};
    lastQ = mem.exists(key) ? mem[key] : 36'h000000000;
    if (rowOpen && !writeEnable_n && !dataOe_n) begin
      for (int i = 0; i < 4; i++) if (!colStrobe_n[i]) lastQ[9*i +: 9] = dataOut[9*i +: 9];
      mem[key] = lastQ;
    end
  end
  // Off-bus data shows the inverse, so a controller sampling at the wrong time sees garbage.
  assign #ACC_NS dataIn = (rowOpen && colLow && writeEnable_n) ? lastQ : ~lastQ;
endmodule : pdm_dram_model
`default_nettype wire

// ### tb_pdm_ctrl.sv
// Self-checking bench: controller against the DRAM module model and a reference memory.
// Assumes the checker and model files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb_pdm_ctrl;
  logic mclk, rst_n, reqValid, reqWrite, reqSide, reqPageNext, reqReady, rspValid, initDone;
  logic rowOne_n, rowTwo_n, we_n, oe_n;
  logic [17:0] reqAddr;
  logic [35:0] reqWdata, rspRdata, dataIn, dataOut;
  logic [3:0] reqLanes, col_n;
  logic [8:0] addrBus;
  logic [35:0] refMem [bit [18:0]];
  int errors, checked, seed;
  // Short power-up and refresh counts keep the run brief.
  pdm_ctrl #(.POWERUP_CYC(10), .REFRESH_CYC(40)) dut_u (.mclk, .rst_n, .reqValid, .reqWrite,
    .reqSide, .reqAddr, .reqWdata, .reqLanes, .reqPageNext, .reqReady, .rspValid, .rspRdata,
    .initDone, .row_strobe_side_one_n(rowOne_n), .row_strobe_side_two_n(rowTwo_n),
    .column_strobe_lane0_n(col_n[0]), .column_strobe_lane1_n(col_n[1]),
    .column_strobe_lane2_n(col_n[2]), .column_strobe_lane3_n(col_n[3]), .writeEnable_n(we_n),
    .muxed_address_bus(addrBus), .dataIn, .dataOut, .dataOe_n(oe_n));
  pdm_dram_model #(.ACC_NS(100)) mem_u (.row_strobe_side_one_n(rowOne_n),
    .row_strobe_side_two_n(rowTwo_n), .colStrobe_n(col_n), .writeEnable_n(we_n),
    .muxed_address_bus(addrBus), .dataOut, .dataOe_n(oe_n), .dataIn);
  // Clock generator.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // One request, held until taken, then the answer; reads compare with the reference.
  task automatic xfer(input logic w, input logic s, input logic [17:0] a, input logic [35:0] d,
    input logic [3:0] ln, input logic pg);
    logic [18:0] k;
    logic [35:0] e;
    int n;
    k = {s, a};
    e = refMem.exists(k) ? refMem[k] : 36'h000000000;
    for (int i = 0; i < 4; i++) if (w && ln[i]) e[9*i +: 9] = d[9*i +: 9];
    reqValid <= 1'b1;
    reqWrite <= w;
    reqSide <= s;
    reqAddr <= a;
    reqWdata <= d;
    reqLanes <= ln;
    reqPageNext <= pg;
    n = 0;
    do begin @(posedge mclk); n++; end while (reqReady !== 1'b1 && n < 400);
    reqValid <= 1'b0;
    // Scramble address and data once taken, so a late read of them by the design shows up.
    reqAddr <= 18'($random(seed));
    reqWdata <= 36'({$random(seed), $random(seed)});
    while (rspValid !== 1'b1 && n < 400) begin @(posedge mclk); n++; end
    if (n >= 400) begin
      errors++;
      finish_test();
    end
    if (w) refMem[k] = e;
    else check(rspRdata, e);
  endtask : xfer
  // Main sequence: reset, wake-up, random traffic, then a page burst at the top columns.
  initial begin
    logic [17:0] aq [$];
    logic sq [$];
    logic [3:0] ln;
    int n;
    {errors, checked, seed} = {32'sd0, 32'sd0, 32'sd44};
    {rst_n, reqValid, reqWrite, reqSide, reqPageNext} = 5'h00;
    {reqAddr, reqWdata, reqLanes} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (n = 0; n < 2000 && initDone !== 1'b1; n++) @(posedge mclk);
    check({35'h000000000, initDone}, 36'h000000001);
    for (int i = 0; i < 12; i++) begin
      aq.push_back($random(seed));
      sq.push_back($random(seed));
      ln = $random(seed);
      xfer(1'b1, sq[i], aq[i], {$random(seed), $random(seed)}, (ln == 4'h0) ? 4'hF : ln, 1'b0);
    end
    foreach (aq[i]) xfer(1'b0, sq[i], aq[i], 36'h000000000, 4'hF, 1'b0);
    for (int j = 0; j < 8; j++) begin
      xfer(j < 4, 1'b1, {9'h1A5, 9'h1FC + 9'(j % 4)}, {$random(seed), $random(seed)}, 4'hF, 1'b1);
    end
    finish_test();
  end
endmodule : tb_pdm_ctrl
bind pdm_ctrl pdm_ctrl_assertions #(.POWERUP_CYC(POWERUP_CYC), .REFRESH_CYC(REFRESH_CYC)) chk_u (
  .mclk, .rst_n, .reqReady, .rspValid, .initDone, .row_strobe_side_one_n, .row_strobe_side_two_n,
  .column_strobe_lane0_n, .column_strobe_lane1_n, .column_strobe_lane2_n, .column_strobe_lane3_n,
  .writeEnable_n, .muxed_address_bus, .dataOe_n);
`default_nettype wire
